// file: bapseq_approval.sv
`timescale 1ns/1ps
// approval logic: grants after a delay, or never while held
module bapseq_approval (
  input  wire logic       clk_i,
  input  wire logic       ready_i,
  input  wire logic       hold_i,
  input  wire logic [3:0] delay_i,
  output logic            permit_o
);
  logic [3:0] cnt;
  // unknown ready counts as idle, so no grant before reset settles
  always_ff @(posedge clk_i) begin
    if (ready_i !== 1'b1) begin
      cnt      <= 4'h0;
      permit_o <= 1'b0;
    end else if (!hold_i) begin
      if (cnt >= delay_i) permit_o <= 1'b1;
      else cnt <= cnt + 4'h1;
    end
  end
endmodule

// file: bapseq_cfg.svh
`ifndef BAPSEQ_CFG_SVH
`define BAPSEQ_CFG_SVH

// clock period and permit time unit
`define BAPS_CLK_NS         25
`define BAPS_TICK_NS        1000000

// logging parameter bit positions
`define BAPS_LOG_CMD_BIT    4
`define BAPS_LOG_STATE_BIT  5

// group breaker staging settings
`define BAPS_STAGE_FIRST    16'h0000
`define BAPS_STAGE_ALL      16'h7530

// event codes
`define BAPS_EVT_GRP_CLOSE_CMD  16'h0406
`define BAPS_EVT_GRP_OPEN_CMD   16'h0407
`define BAPS_EVT_GRP_CLOSED     16'h0408
`define BAPS_EVT_GRP_OPEN       16'h0409
`define BAPS_EVT_MNS_CLOSE_CMD  16'h040B
`define BAPS_EVT_MNS_OPEN_CMD   16'h040C
`define BAPS_EVT_MNS_CLOSED     16'h040D
`define BAPS_EVT_MNS_OPEN       16'h040E

`endif

// file: bapseq_permit.sv
`timescale 1ns/1ps
module bapseq_permit import bapseq_pkg::*; #(
  parameter int TW = 16
) (
  input  wire logic          sys_clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          tick_i,
  input  wire logic          req_i,
  input  wire logic          skip_i,
  input  wire logic          en_i,
  input  wire logic          permit_i,
  input  wire logic [TW-1:0] limit_i,
  output logic               ready_o,
  output logic               go_o,
  output logic               abandon_o
);
  baps_perm_e    state;
  baps_perm_e    next_state;
  logic [TW-1:0] cnt;
  logic [TW-1:0] next_cnt;
  logic          next_ready;
  logic          next_go;
  logic          next_abandon;

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_ready   = 1'b0;
    next_go      = 1'b0;
    next_abandon = 1'b0;
    case (state)
      BAPS_P_IDLE: begin
        if (req_i) begin
          if (!en_i || skip_i) begin
            next_go    = 1'b1;
            next_state = BAPS_P_DONE;
          end else begin
            next_ready = 1'b1;
            next_cnt   = '0;
            next_state = BAPS_P_WAIT;
          end
        end
      end
      BAPS_P_WAIT: begin
        if (!req_i) begin
          next_state = BAPS_P_IDLE;
        end else if (permit_i || skip_i) begin
          next_go    = 1'b1;
          next_state = BAPS_P_DONE;
        end else if (limit_i != '0 && cnt >= limit_i) begin
          next_abandon = 1'b1;
          next_state   = BAPS_P_DONE;
        end else begin
          next_ready = 1'b1;
          // saturates, never wraps
          if (tick_i && cnt < limit_i) begin
            next_cnt = cnt + 1'b1;
          end
        end
      end
      default: begin
        // no retry until the request goes away
        if (!req_i) begin
          next_state = BAPS_P_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state     <= BAPS_P_IDLE;
      cnt       <= '0;
      ready_o   <= 1'b0;
      go_o      <= 1'b0;
      abandon_o <= 1'b0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      ready_o   <= next_ready;
      go_o      <= next_go;
      abandon_o <= next_abandon;
    end
  end

  sequence s_asked;
    state == BAPS_P_WAIT && req_i && permit_i;
  endsequence

  AST_PERMIT_GO: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    s_asked |=> go_o && !ready_o) else $error("permit did not give command");
  AST_SKIP_GO: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (state == BAPS_P_IDLE && req_i && (skip_i || !en_i)) |=> go_o && !ready_o)
    else $error("skipped wait did not command at once");
  AST_NO_TIMEOUT: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (state == BAPS_P_WAIT && limit_i == '0) |=> !abandon_o) else $error("zero limit abandoned wait");
  AST_READY_DROP: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $fell(ready_o) |-> (go_o || abandon_o || !$past(req_i))) else $error("ready dropped without cause");
endmodule

// file: bapseq_pkg.sv
package bapseq_pkg;
  typedef enum logic [1:0] {BAPS_P_IDLE, BAPS_P_WAIT, BAPS_P_DONE} baps_perm_e;
  typedef logic [15:0] baps_evt_t;
endpackage

// file: bapseq_top.sv
`timescale 1ns/1ps
`include "bapseq_cfg.svh"
// What this block does
// - mains open: ready, await permit, then open
// - mains open wait skipped in listed cases
// - permit wait timed; zero waits forever
// - mains close: ready, await permit, then close
// - mains close wait skipped in listed cases
// - group open: ready, await permit, then open
// - group open wait skipped in listed cases
// - group close permit skipped only off/manual
// - parallel plant keeps mains closed normally
// - standby: mains opens first, recloses after
// - parallel: group closes before gensets unsynced
// - else group closes synced after genset closes
// - standby group staged by power setting
// - low power warning then close anyway
// - immediate supply closes after first genset
// - log command and state changes by bits
// - export status, command, coil, pulse flags
// - any genset closed from link or input
module bapseq_top import bapseq_pkg::*; #(
  parameter int TW       = 16,
  parameter int PW       = 16,
  parameter int TICK_CYC = `BAPS_TICK_NS / `BAPS_CLK_NS
) (
  input  wire logic          sys_clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          off_mode_i,
  input  wire logic          manual_mode_i,
  input  wire logic          standby_plant_i,
  input  wire logic          alarms_i,
  input  wire logic          gensets_req_i,
  input  wire logic          prot_trip_i,
  input  wire logic          mains_fail_i,
  input  wire logic          mains_iface_dev_i,
  input  wire logic          transfer_mode_i,
  input  wire logic          load_moved_i,
  input  wire logic          mains_managed_i,
  input  wire logic          mains_syncable_i,
  input  wire logic          mains_closed_fb_i,
  input  wire logic          group_present_i,
  input  wire logic          group_managed_i,
  input  wire logic          group_nosync_ok_i,
  input  wire logic          group_gen_bus_fed_i,
  input  wire logic          gensets_first_i,
  input  wire logic          group_closed_fb_i,
  input  wire logic          plant_can_link_closed_i,
  input  wire logic          other_gensets_closed_in_i,
  input  wire logic          all_gensets_closed_i,
  input  wire logic [PW-1:0] closed_power_i,
  input  wire logic [PW-1:0] stage_setting_i,
  input  wire logic          immediate_supply_in_i,
  input  wire logic [3:0]    permit_en_i,
  input  wire logic          mains_open_permit_in_i,
  input  wire logic          mains_close_permit_in_i,
  input  wire logic          group_open_permit_in_i,
  input  wire logic          group_close_permit_in_i,
  input  wire logic [TW-1:0] mains_open_limit_i,
  input  wire logic [TW-1:0] mains_close_limit_i,
  input  wire logic [TW-1:0] group_open_limit_i,
  input  wire logic [TW-1:0] group_close_limit_i,
  input  wire logic [7:0]    log_cfg_i,
  output logic               mains_ready_open_out_o,
  output logic               mains_ready_close_out_o,
  output logic               group_ready_open_out_o,
  output logic               group_ready_close_out_o,
  output logic               mains_close_cmd_o,
  output logic               mains_close_sync_o,
  output logic               mains_uv_coil_o,
  output logic               mains_open_pulse_o,
  output logic               mains_close_pulse_o,
  output logic               mains_status_o,
  output logic               group_close_cmd_o,
  output logic               group_close_sync_o,
  output logic               group_uv_coil_o,
  output logic               group_open_pulse_o,
  output logic               group_close_pulse_o,
  output logic               group_status_o,
  output logic               any_genset_closed_o,
  output logic               low_power_warning_o,
  output logic               event_valid_o,
  output baps_evt_t          event_code_o
);
  localparam int TCW = $clog2(TICK_CYC + 1);

  logic [TCW-1:0] tick_cnt;
  logic [TCW-1:0] next_tick_cnt;
  logic           tick;
  logic           next_tick;

  // permit time base
  always_comb begin
    next_tick     = 1'b0;
    next_tick_cnt = tick_cnt + 1'b1;
    if (tick_cnt == TCW'(TICK_CYC - 1)) begin
      next_tick_cnt = '0;
      next_tick     = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick     <= next_tick;
    end
  end

  logic auto_mode;
  logic any_gen;
  logic stage_ok;
  logic nosync_first;
  logic mop_req;
  logic mcl_req;
  logic gop_req;
  logic gcl_req;
  logic mop_skip;
  logic mcl_skip;
  logic gop_skip;
  logic gcl_skip;
  logic mop_go;
  logic mcl_go;
  logic gop_go;
  logic gcl_go;
  logic mains_opened_by_us;
  logic group_closed_by_us;

  assign auto_mode = !off_mode_i && !manual_mode_i;
  assign any_gen   = any_genset_closed_o;

  assign stage_ok = any_gen && (immediate_supply_in_i || stage_setting_i == PW'(`BAPS_STAGE_FIRST)
                    || (stage_setting_i == PW'(`BAPS_STAGE_ALL) ? all_gensets_closed_i
                        : (closed_power_i > stage_setting_i || all_gensets_closed_i)));
  assign nosync_first = group_nosync_ok_i && !any_gen && !group_gen_bus_fed_i && !gensets_first_i;

  assign mop_req = mains_managed_i && mains_close_cmd_o && auto_mode
                   && (prot_trip_i || (standby_plant_i ? gensets_req_i
                       : ((mains_fail_i && mains_iface_dev_i) || (transfer_mode_i && load_moved_i))));
  assign mcl_req = mains_managed_i && !mains_close_cmd_o && auto_mode && !prot_trip_i
                   && (standby_plant_i
                       ? (!gensets_req_i && (mains_syncable_i || (group_present_i ? !group_closed_fb_i : !any_gen)))
                       : !(mains_fail_i && mains_iface_dev_i) && !(transfer_mode_i && load_moved_i));
  assign gcl_req = group_present_i && group_managed_i && !group_close_cmd_o && auto_mode && gensets_req_i
                   && !alarms_i && (standby_plant_i ? (!mains_closed_fb_i && stage_ok) : (nosync_first || any_gen));
  // synced mains goes back first
  assign gop_req = group_present_i && group_managed_i && group_close_cmd_o
                   && (off_mode_i || (auto_mode && (prot_trip_i || alarms_i
                       || (!gensets_req_i && (!standby_plant_i || !mains_syncable_i || mains_closed_fb_i)))));

  assign mop_skip = !auto_mode || !group_present_i || group_closed_fb_i || prot_trip_i;
  assign mcl_skip = !auto_mode || alarms_i || (!gensets_req_i && !mains_opened_by_us);
  assign gop_skip = !auto_mode || prot_trip_i || alarms_i || (!gensets_req_i && !group_closed_by_us);
  assign gcl_skip = !auto_mode;

  bapseq_permit #(.TW(TW)) u_mop (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .tick_i    (tick),
    .req_i     (mop_req),
    .skip_i    (mop_skip),
    .en_i      (permit_en_i[0]),
    .permit_i  (mains_open_permit_in_i),
    .limit_i   (mains_open_limit_i),
    .ready_o   (mains_ready_open_out_o),
    .go_o      (mop_go),
    .abandon_o ()
  );

  bapseq_permit #(.TW(TW)) u_mcl (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .tick_i    (tick),
    .req_i     (mcl_req),
    .skip_i    (mcl_skip),
    .en_i      (permit_en_i[1]),
    .permit_i  (mains_close_permit_in_i),
    .limit_i   (mains_close_limit_i),
    .ready_o   (mains_ready_close_out_o),
    .go_o      (mcl_go),
    .abandon_o ()
  );

  bapseq_permit #(.TW(TW)) u_gop (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .tick_i    (tick),
    .req_i     (gop_req),
    .skip_i    (gop_skip),
    .en_i      (permit_en_i[2]),
    .permit_i  (group_open_permit_in_i),
    .limit_i   (group_open_limit_i),
    .ready_o   (group_ready_open_out_o),
    .go_o      (gop_go),
    .abandon_o ()
  );

  bapseq_permit #(.TW(TW)) u_gcl (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .tick_i    (tick),
    .req_i     (gcl_req),
    .skip_i    (gcl_skip),
    .en_i      (permit_en_i[3]),
    .permit_i  (group_close_permit_in_i),
    .limit_i   (group_close_limit_i),
    .ready_o   (group_ready_close_out_o),
    .go_o      (gcl_go),
    .abandon_o ()
  );

  logic next_mcmd;
  logic next_gcmd;
  logic next_msync;
  logic next_gsync;
  logic next_m_by_us;
  logic next_g_by_us;

  // breaker commands; go pulses act only on the state they were asked from
  always_comb begin
    next_mcmd    = mains_close_cmd_o;
    next_gcmd    = group_close_cmd_o;
    next_msync   = mains_close_sync_o;
    next_gsync   = group_close_sync_o;
    next_m_by_us = mains_opened_by_us;
    next_g_by_us = group_closed_by_us;
    if (mop_go && mains_close_cmd_o) begin
      next_mcmd    = 1'b0;
      next_m_by_us = auto_mode;
    end else if (mcl_go && !mains_close_cmd_o) begin
      next_mcmd    = 1'b1;
      next_msync   = mains_syncable_i && group_closed_fb_i;
      next_m_by_us = 1'b0;
    end
    if (gop_go && group_close_cmd_o) begin
      next_gcmd    = 1'b0;
      next_g_by_us = 1'b0;
    end else if (gcl_go && !group_close_cmd_o) begin
      next_gcmd    = 1'b1;
      next_gsync   = !standby_plant_i && !nosync_first;
      next_g_by_us = auto_mode;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mains_close_cmd_o   <= 1'b0;
      group_close_cmd_o   <= 1'b0;
      mains_close_sync_o  <= 1'b0;
      group_close_sync_o  <= 1'b0;
      mains_opened_by_us  <= 1'b0;
      group_closed_by_us  <= 1'b0;
      mains_uv_coil_o     <= 1'b0;
      group_uv_coil_o     <= 1'b0;
      mains_open_pulse_o  <= 1'b0;
      mains_close_pulse_o <= 1'b0;
      group_open_pulse_o  <= 1'b0;
      group_close_pulse_o <= 1'b0;
      mains_status_o      <= 1'b0;
      group_status_o      <= 1'b0;
    end else begin
      mains_close_cmd_o   <= next_mcmd;
      group_close_cmd_o   <= next_gcmd;
      mains_close_sync_o  <= next_msync;
      group_close_sync_o  <= next_gsync;
      mains_opened_by_us  <= next_m_by_us;
      group_closed_by_us  <= next_g_by_us;
      mains_uv_coil_o     <= next_mcmd;
      group_uv_coil_o     <= next_gcmd;
      mains_open_pulse_o  <= mains_close_cmd_o && !next_mcmd;
      mains_close_pulse_o <= !mains_close_cmd_o && next_mcmd;
      group_open_pulse_o  <= group_close_cmd_o && !next_gcmd;
      group_close_pulse_o <= !group_close_cmd_o && next_gcmd;
      mains_status_o      <= mains_closed_fb_i;
      group_status_o      <= group_closed_fb_i;
    end
  end

  logic      mcmd_q;
  logic      gcmd_q;
  logic      mfb_q;
  logic      gfb_q;
  logic      next_mcmd_q;
  logic      next_gcmd_q;
  logic      next_mfb_q;
  logic      next_gfb_q;
  logic      next_ev;
  baps_evt_t next_code;

  // event logging
  // one change per cycle; the others wait, but a change undone while waiting is not logged
  always_comb begin
    next_mcmd_q = mcmd_q;
    next_gcmd_q = gcmd_q;
    next_mfb_q  = mfb_q;
    next_gfb_q  = gfb_q;
    next_ev     = 1'b0;
    next_code   = event_code_o;
    if (mains_close_cmd_o != mcmd_q) begin
      next_mcmd_q = mains_close_cmd_o;
      next_ev     = log_cfg_i[`BAPS_LOG_CMD_BIT];
      next_code   = mains_close_cmd_o ? `BAPS_EVT_MNS_CLOSE_CMD : `BAPS_EVT_MNS_OPEN_CMD;
    end else if (group_close_cmd_o != gcmd_q) begin
      next_gcmd_q = group_close_cmd_o;
      next_ev     = log_cfg_i[`BAPS_LOG_CMD_BIT];
      next_code   = group_close_cmd_o ? `BAPS_EVT_GRP_CLOSE_CMD : `BAPS_EVT_GRP_OPEN_CMD;
    end else if (mains_status_o != mfb_q) begin
      next_mfb_q = mains_status_o;
      next_ev    = log_cfg_i[`BAPS_LOG_STATE_BIT];
      next_code  = mains_status_o ? `BAPS_EVT_MNS_CLOSED : `BAPS_EVT_MNS_OPEN;
    end else if (group_status_o != gfb_q) begin
      next_gfb_q = group_status_o;
      next_ev    = log_cfg_i[`BAPS_LOG_STATE_BIT];
      next_code  = group_status_o ? `BAPS_EVT_GRP_CLOSED : `BAPS_EVT_GRP_OPEN;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mcmd_q        <= 1'b0;
      gcmd_q        <= 1'b0;
      mfb_q         <= 1'b0;
      gfb_q         <= 1'b0;
      event_valid_o <= 1'b0;
      event_code_o  <= '0;
    end else begin
      mcmd_q        <= next_mcmd_q;
      gcmd_q        <= next_gcmd_q;
      mfb_q         <= next_mfb_q;
      gfb_q         <= next_gfb_q;
      event_valid_o <= next_ev;
      event_code_o  <= next_code;
    end
  end

  logic next_any;
  logic next_warn;

  always_comb begin
    next_any  = plant_can_link_closed_i || other_gensets_closed_in_i;
    next_warn = low_power_warning_o;
    if (standby_plant_i && gcl_req && all_gensets_closed_i && !immediate_supply_in_i
        && stage_setting_i != PW'(`BAPS_STAGE_FIRST) && stage_setting_i != PW'(`BAPS_STAGE_ALL)
        && closed_power_i <= stage_setting_i) begin
      next_warn = 1'b1;
    end else if (!gensets_req_i) begin
      next_warn = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      any_genset_closed_o <= 1'b0;
      low_power_warning_o <= 1'b0;
    end else begin
      any_genset_closed_o <= next_any;
      low_power_warning_o <= next_warn;
    end
  end

  sequence s_par_hold;
    (auto_mode && !standby_plant_i && !prot_trip_i && !mains_fail_i && !transfer_mode_i) [*2];
  endsequence

  AST_MAINS_OPEN_GO: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $fell(mains_close_cmd_o) |-> $past(mop_go)) else $error("mains opened without go");
  AST_MAINS_PAR_HOLD: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (s_par_hold ##0 mains_close_cmd_o) |=> mains_close_cmd_o) else $error("parallel mains opened");
  AST_ANY_GENSET: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    other_gensets_closed_in_i |=> any_genset_closed_o) else $error("other gensets input ignored");
  AST_EVT_CMD: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    ($changed(mains_close_cmd_o) && log_cfg_i[`BAPS_LOG_CMD_BIT]) |=> event_valid_o
      && event_code_o == (mains_close_cmd_o ? `BAPS_EVT_MNS_CLOSE_CMD : `BAPS_EVT_MNS_OPEN_CMD))
    else $error("mains command change not logged");
  AST_CLOSE_PULSE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(group_close_cmd_o) |-> group_close_pulse_o && group_uv_coil_o ##1 !group_close_pulse_o)
    else $error("group closure pulse wrong");
  AST_LOWPWR: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(low_power_warning_o) |-> $past(all_gensets_closed_i && closed_power_i <= stage_setting_i))
    else $error("low power warning without cause");
  AST_IMM_SUPPLY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    ($rose(gcl_req) && immediate_supply_in_i) |-> ##[1:2] (group_ready_close_out_o || group_close_cmd_o))
    else $error("immediate supply did not close group");
endmodule

// file: test_breaker_auto_permit_sequencer.sv
`timescale 1ns/1ps
module test_breaker_auto_permit_sequencer;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic off_mode_i, manual_mode_i, standby_plant_i, alarms_i, gensets_req_i, prot_trip_i, mains_fail_i;
  logic mains_iface_dev_i, transfer_mode_i, load_moved_i, mains_managed_i, mains_syncable_i, mains_closed_fb_i;
  logic group_present_i, group_managed_i, group_nosync_ok_i, group_gen_bus_fed_i, gensets_first_i;
  logic group_closed_fb_i, plant_can_link_closed_i, other_gensets_closed_in_i, all_gensets_closed_i;
  logic immediate_supply_in_i;
  logic [15:0] closed_power_i, stage_setting_i, mains_open_limit_i, mains_close_limit_i;
  logic [15:0] group_open_limit_i, group_close_limit_i;
  logic [3:0]  permit_en_i, hold, dly, permit;
  logic [7:0]  log_cfg_i;
  logic mains_ready_open_out_o, mains_ready_close_out_o, group_ready_open_out_o, group_ready_close_out_o;
  logic mains_close_cmd_o, mains_close_sync_o, mains_uv_coil_o, mains_open_pulse_o, mains_close_pulse_o;
  logic mains_status_o, group_close_cmd_o, group_close_sync_o, group_uv_coil_o, group_open_pulse_o;
  logic group_close_pulse_o, group_status_o, any_genset_closed_o, low_power_warning_o, event_valid_o;
  bapseq_pkg::baps_evt_t event_code_o;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h0000_9604;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  wire logic [3:0] ready = {group_ready_close_out_o, group_ready_open_out_o,
                            mains_ready_close_out_o, mains_ready_open_out_o};
  wire logic [5:0] obs = {group_close_cmd_o, mains_close_cmd_o, ready};

  always #12.5 sys_clk_i = ~sys_clk_i;

  for (genvar g = 0; g < 4; g++) begin : appr
    bapseq_approval u (.clk_i(sys_clk_i), .ready_i(ready[g]), .hold_i(hold[g]), .delay_i(dly),
                       .permit_o(permit[g]));
  end

  // short tick keeps permit timeouts to a few cycles
  bapseq_top #(.TICK_CYC(4)) dut (.sys_clk_i, .sys_rst_i, .off_mode_i, .manual_mode_i, .standby_plant_i,
    .alarms_i, .gensets_req_i, .prot_trip_i, .mains_fail_i, .mains_iface_dev_i, .transfer_mode_i,
    .load_moved_i, .mains_managed_i, .mains_syncable_i, .mains_closed_fb_i, .group_present_i,
    .group_managed_i, .group_nosync_ok_i, .group_gen_bus_fed_i, .gensets_first_i, .group_closed_fb_i,
    .plant_can_link_closed_i, .other_gensets_closed_in_i, .all_gensets_closed_i, .closed_power_i,
    .stage_setting_i, .immediate_supply_in_i, .permit_en_i, .mains_open_permit_in_i(permit[0]),
    .mains_close_permit_in_i(permit[1]), .group_open_permit_in_i(permit[2]),
    .group_close_permit_in_i(permit[3]), .mains_open_limit_i, .mains_close_limit_i, .group_open_limit_i,
    .group_close_limit_i, .log_cfg_i, .mains_ready_open_out_o, .mains_ready_close_out_o,
    .group_ready_open_out_o, .group_ready_close_out_o, .mains_close_cmd_o, .mains_close_sync_o,
    .mains_uv_coil_o, .mains_open_pulse_o, .mains_close_pulse_o, .mains_status_o, .group_close_cmd_o,
    .group_close_sync_o, .group_uv_coil_o, .group_open_pulse_o, .group_close_pulse_o, .group_status_o,
    .any_genset_closed_o, .low_power_warning_o, .event_valid_o, .event_code_o);

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // bounded wait on one observed output, sampled at falling edges
  task automatic await(input int b, input logic v, input int lim);
    n = 0;
    while (obs[b] !== v && n < lim) begin
      @(negedge sys_clk_i);
      n++;
    end
  endtask

  // next scenario starts on a rising edge with fresh random values
  task automatic step();
    @(posedge sys_clk_i);
    seed = xs(seed);
    dly <= {1'b0, seed[2:0]} + 4'h1;
    closed_power_i <= seed[31:16];
    stage_setting_i <= seed[15:0];
  endtask

  // the watcher keeps the run bounded and matches each event to the oldest note
  always @(negedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      print_verdict();
    end
    if (!sys_rst_i && event_valid_o === 1'b1) begin
      if (exp_q.size() == 0) check("event_extra", event_code_o, 16'hFFFF);
      else check("event_code", event_code_o, exp_q.pop_front());
    end
  end

  initial begin
    {off_mode_i, standby_plant_i, alarms_i, prot_trip_i, mains_fail_i, transfer_mode_i, load_moved_i,
     mains_syncable_i, mains_closed_fb_i, group_managed_i, group_nosync_ok_i, group_gen_bus_fed_i,
     gensets_first_i, group_closed_fb_i, plant_can_link_closed_i, other_gensets_closed_in_i,
     all_gensets_closed_i, immediate_supply_in_i} = '0;
    {manual_mode_i, gensets_req_i, mains_managed_i, group_present_i, mains_iface_dev_i} = 5'h1F;
    {closed_power_i, stage_setting_i, mains_open_limit_i, mains_close_limit_i} = '0;
    {group_open_limit_i, group_close_limit_i} = '0;
    permit_en_i = 4'h0;
    hold = 4'h0;
    dly = 4'h1;
    log_cfg_i = 8'h10;
    repeat (16) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      step();
      {plant_can_link_closed_i, other_gensets_closed_in_i} <= i[1:0];
      mains_closed_fb_i <= i[0];
      repeat (3) @(negedge sys_clk_i);
      check("any_genset", any_genset_closed_o, 16'(i != 0));
      check("mains_status", mains_status_o, 16'(i[0]));
    end
    step();
    {plant_can_link_closed_i, other_gensets_closed_in_i, mains_closed_fb_i} <= 3'h0;
    permit_en_i <= 4'h3;
    manual_mode_i <= 1'b0;
    exp_q.push_back(16'h040B);
    await(1, 1'b1, 20);
    check("ready_close", obs[1], 16'h1);
    await(4, 1'b1, 40);
    check("close_cmd", obs[4], 16'h1);
    check("ready_close_drop", obs[1], 16'h0);
    check("uv_coil", mains_uv_coil_o, 16'h1);
    check("close_pulse", mains_close_pulse_o, 16'h1);
    check("close_sync", mains_close_sync_o, 16'h0);
    step();
    hold <= 4'h1;
    mains_fail_i <= 1'b1;
    await(0, 1'b1, 20);
    check("ready_open", obs[0], 16'h1);
    repeat (100) @(negedge sys_clk_i);
    check("wait_forever", obs[4:0], 16'h11);
    step();
    hold <= 4'h0;
    exp_q.push_back(16'h040C);
    await(4, 1'b0, 40);
    check("open_cmd", obs[4], 16'h0);
    check("open_pulse", mains_open_pulse_o, 16'h1);
    check("ready_open_drop", obs[0], 16'h0);
    step();
    permit_en_i <= 4'h1;
    mains_fail_i <= 1'b0;
    exp_q.push_back(16'h040B);
    await(4, 1'b1, 20);
    check("close_unconfigured", 16'(n < 5), 16'h1);
    step();
    permit_en_i <= 4'h3;
    hold <= 4'h3;
    mains_fail_i <= 1'b1;
    prot_trip_i <= 1'b1;
    exp_q.push_back(16'h040C);
    await(4, 1'b0, 20);
    check("trip_open_fast", 16'(n < 5), 16'h1);
    step();
    prot_trip_i <= 1'b0;
    mains_fail_i <= 1'b0;
    mains_close_limit_i <= 16'h0002;
    await(1, 1'b1, 20);
    check("ready_close_again", obs[1], 16'h1);
    await(1, 1'b0, 30);
    check("timeout_len", 16'(n >= 4 && n <= 12), 16'h1);
    repeat (10) @(negedge sys_clk_i);
    check("timeout_no_cmd", obs[4:0], 16'h0);
    step();
    group_managed_i <= 1'b1;
    group_nosync_ok_i <= 1'b1;
    immediate_supply_in_i <= 1'b1;
    exp_q.push_back(16'h0406);
    await(5, 1'b1, 20);
    check("group_close", obs[5], 16'h1);
    check("group_unsynced", group_close_sync_o, 16'h0);
    check("group_close_pulse", group_close_pulse_o, 16'h1);
    check("group_uv_coil", group_uv_coil_o, 16'h1);
    check("low_power", low_power_warning_o, 16'h0);
    step();
    alarms_i <= 1'b1;
    exp_q.push_back(16'h0407);
    await(5, 1'b0, 20);
    check("group_open_fast", 16'(n < 5), 16'h1);
    check("group_open_pulse", group_open_pulse_o, 16'h1);
    repeat (3) @(negedge sys_clk_i);
    check("events_left", 16'(exp_q.size()), 16'h0);
    print_verdict();
  end
endmodule
